// file: hw/acc_conv_ctrl.sv
// conversion sequencer with axi4-lite register slave
// Contract
// - converter held off in reset and while channel select is all ones
// - after completion and before next start, sit idle at lowest power
// - 12/10-bit modes resolve 12 raw bits; 8-bit mode resolves 9 bits
// - 10-bit rounds into high and low; 8-bit rounds into low only
// - after storing result set done flag; interrupt if enable set then
// - compare against compare values only when compare enable set, any mode
// - four clock sources selectable; bus clock after reset
// - internal async clock lives inside converter, kept running in wait/stop3
// - selected source divided by 1, 2, 4 or 8 per divider field
// - disabled pin: output hi-z, input reads zero, pullup off
// - upper pin disable covers channels 16 to 23, bit 7 is 23
// - hardware trigger rising edge starts conversion; ignored while busy
// - continuous with hardware trigger: only first edge launches sequence
// - software trigger: any write to control one starts unless channel all ones
// - continuous mode restarts after every transfer until aborted
// - 12/10-bit modes: high read without low read blocks transfer, no flag, result lost
// - blocked transfer restarts, except single compare-false which ends
// - abort on writes to sc1, sc2, cfg and compare values (not pin disable), reset and stop without async clock
// - abort keeps last result; reset returns results to reset values
// - async clock generator on only when conversion starts with it selected
// - low power bit selects reduced power configuration
// - clock source codes 00 bus, 01 bus/2, 10 alternate, 11 async
// - mode codes 00 8-bit, 01 12-bit, 10 10-bit, 11 reserved
// - divider codes 00 /1, 01 /2, 10 /4, 11 /8
module acc_conv_ctrl #(
  parameter int PIN_COUNT = 24
) (
  input wire logic i_core_clk, // bus clock
  input wire logic i_reset_n, // sync reset, active low
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic i_alt_clk_en, // alternate clock tick, one cycle
  input wire logic i_async_clk_en, // internal async clock tick, one cycle
  input wire logic i_hw_trigger, // hardware trigger input level
  input wire logic i_stop_req, // chip entering stop mode, level
  input wire logic i_cmp_bit, // comparator answer for current trial
  output acc_pkg::acc_ana_req_t o_ana, // analog core controls
  output logic o_irq, // done interrupt, level
  output logic [PIN_COUNT-1:0] o_pin_port_dis // forces pin hi-z, input zero, pullup off
);
  if (PIN_COUNT != 24) begin : g_pin_count_check
    $error("acc_conv_ctrl: three 8-bit pin disable registers need PIN_COUNT 24");
  end

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_CONVERT = 2'b10
  } acc_state_t;

  acc_state_t state, next_state;
  logic [7:0] sc1, sc2, cfg, cvh, cvl, res_h, res_l;
  logic [PIN_COUNT-1:0] pin_dis;
  logic [11:0] sar, next_sar;
  logic [3:0] bit_idx, next_bit_idx;
  logic [2:0] div_cnt;
  logic src_prev;
  logic trig_prev;
  logic high_read_pend;
  logic done;

  // bus slave: write takes address and data in either order
  logic aw_hold, w_hold;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_go;
  logic [7:0] wr_byte;
  logic wr_sc1, wr_cfgset;
  assign wr_go = aw_hold && w_hold && !s_axi_bvalid;
  assign wr_byte = w_strb[0] ? w_data[7:0] : 8'h00;
  assign wr_sc1 = wr_go && w_strb[0] && aw_addr == acc_pkg::OFF_SC1;
  assign wr_cfgset = wr_go && w_strb[0] && (aw_addr == acc_pkg::OFF_SC2 || aw_addr == acc_pkg::OFF_CFG
    || aw_addr == acc_pkg::OFF_CVH || aw_addr == acc_pkg::OFF_CVL);

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= acc_pkg::AXI_OKAY;
    end else begin
      s_axi_awready <= !aw_hold && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_hold && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr > acc_pkg::OFF_ANA || aw_addr[1:0] != 2'b00) ? acc_pkg::AXI_SLVERR
          : acc_pkg::AXI_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read path; reading result registers drives the blocking latch
  logic rd_hi, rd_lo;
  assign rd_hi = s_axi_arvalid && s_axi_arready && s_axi_araddr == acc_pkg::OFF_RH;
  assign rd_lo = s_axi_arvalid && s_axi_arready && s_axi_araddr == acc_pkg::OFF_RL;

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= acc_pkg::AXI_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= acc_pkg::AXI_OKAY;
        unique case (s_axi_araddr)
          acc_pkg::OFF_SC1: s_axi_rdata <= {24'h0, done, sc1[6:0]};
          acc_pkg::OFF_SC2: s_axi_rdata <= {24'h0, state != ST_IDLE, sc2[6:0]};
          acc_pkg::OFF_CFG: s_axi_rdata <= {24'h0, cfg};
          acc_pkg::OFF_CVH: s_axi_rdata <= {24'h0, cvh};
          acc_pkg::OFF_CVL: s_axi_rdata <= {24'h0, cvl};
          acc_pkg::OFF_RH: s_axi_rdata <= {24'h0, res_h};
          acc_pkg::OFF_RL: s_axi_rdata <= {24'h0, res_l};
          acc_pkg::OFF_PD_LO: s_axi_rdata <= {24'h0, pin_dis[7:0]};
          acc_pkg::OFF_PD_MID: s_axi_rdata <= {24'h0, pin_dis[15:8]};
          acc_pkg::OFF_PD_UP: s_axi_rdata <= {24'h0, pin_dis[23:16]};
          acc_pkg::OFF_ANA: s_axi_rdata <= {16'h0, o_ana.async_clk_on, state != ST_IDLE, 2'b00, sar};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= acc_pkg::AXI_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // configuration registers
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      sc1 <= acc_pkg::RST_SC1;
      sc2 <= acc_pkg::RST_BYTE;
      cfg <= acc_pkg::RST_BYTE;
      cvh <= acc_pkg::RST_BYTE;
      cvl <= acc_pkg::RST_BYTE;
      pin_dis <= '0;
    end else if (wr_go && w_strb[0]) begin
      unique case (aw_addr)
        acc_pkg::OFF_SC1: sc1 <= wr_byte;
        acc_pkg::OFF_SC2: sc2 <= {1'b0, wr_byte[6:0]};
        acc_pkg::OFF_CFG: cfg <= wr_byte;
        acc_pkg::OFF_CVH: cvh <= {4'h0, wr_byte[3:0]};
        acc_pkg::OFF_CVL: cvl <= wr_byte;
        acc_pkg::OFF_PD_LO: pin_dis[7:0] <= wr_byte;
        acc_pkg::OFF_PD_MID: pin_dis[15:8] <= wr_byte;
        acc_pkg::OFF_PD_UP: pin_dis[23:16] <= wr_byte;
        default: ;
      endcase
    end
  end

  // pin overrides, registered outputs
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) o_pin_port_dis <= '0;
    else o_pin_port_dis <= pin_dis;
  end

  // decoded control
  logic [4:0] chan;
  logic ch_off, cont, hw_trg, cfe, cfgt;
  logic [1:0] div_sel, clk_sel, mode;
  assign chan = sc1[4:0];
  assign ch_off = chan == acc_pkg::CH_OFF;
  assign cont = sc1[acc_pkg::SC1_CONT];
  assign hw_trg = sc2[acc_pkg::SC2_TRG];
  assign cfe = sc2[acc_pkg::SC2_CFE];
  assign cfgt = sc2[acc_pkg::SC2_CFGT];
  assign div_sel = cfg[acc_pkg::CFG_DIV_LO +: 2];
  assign mode = cfg[acc_pkg::CFG_MODE_LO +: 2];
  assign clk_sel = cfg[acc_pkg::CFG_CLK_LO +: 2];

  // source tick: bus/2 via toggle, others as enables
  logic src_tick, conversion_clock_tick;
  logic [2:0] div_mask;
  always_comb begin
    unique case (acc_pkg::acc_clk_src_t'(clk_sel))
      acc_pkg::ACC_CLK_BUS: src_tick = 1'b1;
      acc_pkg::ACC_CLK_BUS2: src_tick = src_prev;
      acc_pkg::ACC_CLK_ALT: src_tick = i_alt_clk_en;
      acc_pkg::ACC_CLK_ASYNC: src_tick = i_async_clk_en;
    endcase
    unique case (div_sel)
      2'b00: div_mask = 3'h0;
      2'b01: div_mask = 3'h1;
      2'b10: div_mask = 3'h3;
      2'b11: div_mask = 3'h7;
    endcase
  end
  assign conversion_clock_tick = src_tick && ((div_cnt & div_mask) == div_mask);

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      src_prev <= 1'b0;
      div_cnt <= 3'h0;
    end else begin
      src_prev <= !src_prev;
      if (state == ST_IDLE) div_cnt <= 3'h0;
      else if (src_tick) div_cnt <= div_cnt + 3'h1;
    end
  end

  // start and abort decisions
  logic trig_edge, start, abort, stop_abort, conv_end, block, cmp_ok, xfer;
  logic [3:0] steps;
  logic [12:0] cmp_diff;
  logic [11:0] cmp_val, raw_res, rounded;
  assign trig_edge = i_hw_trigger && !trig_prev;
  assign stop_abort = i_stop_req && clk_sel != 2'(acc_pkg::ACC_CLK_ASYNC);
  assign abort = wr_sc1 || wr_cfgset || stop_abort;
  assign steps = (mode == 2'(acc_pkg::ACC_MODE_8)) ? acc_pkg::SAR_STEPS_8 : acc_pkg::SAR_STEPS_12;
  assign conv_end = state == ST_CONVERT && conversion_clock_tick && bit_idx == 4'h0;
  assign cmp_val = {cvh[3:0], cvl};
  // rounding adds half of the dropped bits; clamped so full scale never wraps to zero
  always_comb begin
    raw_res = {sar[11:1], i_cmp_bit};
    unique case (acc_pkg::acc_mode_t'(mode))
      acc_pkg::ACC_MODE_10: rounded = &raw_res[11:2] ? 12'h3ff : {2'b00, 10'(({1'b0, raw_res} + 13'h2) >> 2)};
      acc_pkg::ACC_MODE_8: rounded = &raw_res[8:1] ? 12'h0ff : {4'h0, 8'(({4'h0, raw_res[8:0]} + 13'h1) >> 1)};
      default: rounded = raw_res;
    endcase
  end
  assign cmp_diff = {1'b0, rounded} - {1'b0, cmp_val};
  assign cmp_ok = !cfe || (cfgt ? !cmp_diff[12] : cmp_diff[12]);
  assign block = high_read_pend && (mode == 2'(acc_pkg::ACC_MODE_12) || mode == 2'(acc_pkg::ACC_MODE_10));
  assign xfer = conv_end && cmp_ok && !block;
  // start: software write, hardware edge when idle, continuous or block restart
  assign start = (wr_sc1 && !(&wr_byte[4:0]) && !hw_trg)
    || (!abort && state == ST_IDLE && hw_trg && trig_edge && !ch_off)
    || (!abort && conv_end && !ch_off && (cont || (block && cmp_ok)));

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) trig_prev <= 1'b0;
    else trig_prev <= i_hw_trigger;
  end

  // sequencer; analog outputs follow next values so the comparator judges the live trial
  always_comb begin
    next_state = state;
    next_sar = sar;
    next_bit_idx = bit_idx;
    if (start) begin
      next_state = ST_SAMPLE;
      next_sar = 12'h000;
      next_bit_idx = steps;
    end else if (abort || ch_off || conv_end) begin
      next_state = ST_IDLE;
    end else if (conversion_clock_tick) begin
      unique case (state)
        ST_SAMPLE: begin
          next_state = ST_CONVERT;
          next_bit_idx = steps - 4'h1;
          next_sar = 12'h800 >> (4'hc - steps);
        end
        ST_CONVERT: begin
          next_bit_idx = bit_idx - 4'h1;
          next_sar = (sar & ~(12'h001 << bit_idx)) | (12'(i_cmp_bit) << bit_idx) | (12'h001 << (bit_idx - 4'h1));
        end
        default: ;
      endcase
    end
  end
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      state <= ST_IDLE;
      sar <= 12'h000;
      bit_idx <= 4'h0;
    end else begin
      state <= next_state;
      sar <= next_sar;
      bit_idx <= next_bit_idx;
    end
  end

  // results: untouched on abort, cleared only by reset
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      res_h <= acc_pkg::RST_BYTE;
      res_l <= acc_pkg::RST_BYTE;
    end else if (xfer) begin
      res_l <= cfe ? cmp_diff[7:0] : rounded[7:0];
      res_h <= (mode == 2'(acc_pkg::ACC_MODE_8)) ? 8'h00 : {4'h0, cfe ? cmp_diff[11:8] : rounded[11:8]};
    end
  end

  // blocking latch; done flag set wins over clear by a new write
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) high_read_pend <= 1'b0;
    else if (rd_hi) high_read_pend <= 1'b1;
    else if (rd_lo) high_read_pend <= 1'b0;
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) done <= 1'b0;
    else if (xfer) done <= 1'b1;
    else if (wr_sc1 || wr_cfgset || rd_lo) done <= 1'b0;
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_irq <= 1'b0;
      o_ana <= '0;
    end else begin
      o_irq <= (done || xfer) && sc1[acc_pkg::SC1_IEN];
      o_ana.power_on <= next_state != ST_IDLE;
      o_ana.low_power <= cfg[acc_pkg::CFG_LPC];
      o_ana.async_clk_on <= next_state != ST_IDLE && clk_sel == 2'(acc_pkg::ACC_CLK_ASYNC);
      o_ana.channel <= chan;
      o_ana.sample <= next_state == ST_SAMPLE;
      o_ana.trial <= next_sar << (4'hc - steps);
    end
  end

  property p_idle_when_off;
    @(posedge i_core_clk) disable iff (!i_reset_n) ch_off && !start |=> state == ST_IDLE;
  endproperty
  a_idle_when_off: assert property (p_idle_when_off) else $error("busy with channel off");

  property p_done_after_xfer;
    @(posedge i_core_clk) disable iff (!i_reset_n) xfer |=> done;
  endproperty
  a_done_after_xfer: assert property (p_done_after_xfer) else $error("done not set");

  property p_block_no_done;
    @(posedge i_core_clk) disable iff (!i_reset_n) conv_end && block && !done |=> !done;
  endproperty
  a_block_no_done: assert property (p_block_no_done) else $error("done set while blocked");

  property p_abort_keeps;
    @(posedge i_core_clk) disable iff (!i_reset_n) abort && !xfer |=> $stable(res_l) && $stable(res_h);
  endproperty
  a_abort_keeps: assert property (p_abort_keeps) else $error("result changed on abort");

  property p_hw_busy_ignored;
    @(posedge i_core_clk) disable iff (!i_reset_n)
      state == ST_CONVERT && !conv_end && !abort && trig_edge && !ch_off |=> state != ST_SAMPLE;
  endproperty
  a_hw_busy_ignored: assert property (p_hw_busy_ignored) else $error("edge restarted busy");

  property p_abort_idle;
    @(posedge i_core_clk) disable iff (!i_reset_n) stop_abort && !start |=> state == ST_IDLE;
  endproperty
  a_abort_idle: assert property (p_abort_idle) else $error("stop did not abort");

  sequence s_sw_write;
    wr_sc1 && !hw_trg && !(&wr_byte[4:0]);
  endsequence
  property p_sw_start;
    @(posedge i_core_clk) disable iff (!i_reset_n) s_sw_write |=> state == ST_SAMPLE ##1 o_ana.power_on;
  endproperty
  a_sw_start: assert property (p_sw_start) else $error("software start missed");

  property p_async_gate;
    @(posedge i_core_clk) disable iff (!i_reset_n) o_ana.async_clk_on |-> o_ana.power_on;
  endproperty
  a_async_gate: assert property (p_async_gate) else $error("async clock on while idle");
endmodule

// file: hw/acc_pkg.sv
// package: register map, field layout and shared types of the conversion sequencer
package acc_pkg;
  localparam logic [7:0] OFF_SC1 = 8'h00;
  localparam logic [7:0] OFF_SC2 = 8'h04;
  localparam logic [7:0] OFF_CFG = 8'h08;
  localparam logic [7:0] OFF_CVH = 8'h0c;
  localparam logic [7:0] OFF_CVL = 8'h10;
  localparam logic [7:0] OFF_RH = 8'h14;
  localparam logic [7:0] OFF_RL = 8'h18;
  localparam logic [7:0] OFF_PD_LO = 8'h1c;
  localparam logic [7:0] OFF_PD_MID = 8'h20;
  localparam logic [7:0] OFF_PD_UP = 8'h24;
  localparam logic [7:0] OFF_ANA = 8'h28;
  // status_control_one fields
  localparam int SC1_DONE = 7;
  localparam int SC1_IEN = 6;
  localparam int SC1_CONT = 5;
  localparam int SC1_CH_LO = 0;
  localparam logic [4:0] CH_OFF = 5'h1f;
  // status_control_two fields
  localparam int SC2_ACT = 7;
  localparam int SC2_TRG = 6;
  localparam int SC2_CFE = 5;
  localparam int SC2_CFGT = 4;
  // converter_configuration fields
  localparam int CFG_LPC = 7;
  localparam int CFG_DIV_LO = 5;
  localparam int CFG_MODE_LO = 2;
  localparam int CFG_CLK_LO = 0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_SC1 = 8'h1f;
  localparam logic [3:0] SAR_STEPS_12 = 4'hc;
  localparam logic [3:0] SAR_STEPS_8 = 4'h9;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ACC_CLK_BUS = 2'b00,
    ACC_CLK_BUS2 = 2'b01,
    ACC_CLK_ALT = 2'b10,
    ACC_CLK_ASYNC = 2'b11
  } acc_clk_src_t;

  typedef enum logic [1:0] {
    ACC_MODE_8 = 2'b00,
    ACC_MODE_12 = 2'b01,
    ACC_MODE_10 = 2'b10,
    ACC_MODE_RSV = 2'b11
  } acc_mode_t;

  // analog core handshake: bit decision request and comparator answer
  typedef struct packed {
    logic power_on;
    logic low_power;
    logic async_clk_on;
    logic [4:0] channel;
    logic sample;
    logic [11:0] trial;
  } acc_ana_req_t;
endpackage

// file: tb/acc_ana_model.sv
// analog core stand-in: sample-and-hold plus comparator
module acc_ana_model (
  input wire logic i_core_clk, // bus clock
  input wire acc_pkg::acc_ana_req_t i_ana, // sequencer controls
  input wire logic [11:0] i_level, // analog input level
  output logic o_cmp_bit // comparator answer
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] held = 12'h000;
  logic junk = 1'b0;
  // held level: input changes after sampling must not leak into the result
  always @(posedge i_core_clk) begin
    if (i_ana.sample) begin
      held <= i_level;
    end
    junk <= ~junk;
  end
  // unpowered comparator gives no stable answer
  assign o_cmp_bit = i_ana.power_on ? (held >= i_ana.trial) : junk;
endmodule

// file: tb/tb.sv
// register-level testbench of the conversion sequencer
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin num_errors++; \
  $display("ERROR %s exp %0h got %0h", nm, ex, got); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, reset_n = 0;
  logic [7:0] awaddr = 0, araddr = 0, rv;
  logic [31:0] wdata = 0, rdata;
  logic [3:0] strb = 4'hf;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, irq, cmp_bit, seen = 0;
  logic [1:0] bresp, rresp, rr;
  logic alt_en = 0, async_en = 0, hw_trig = 0, stop_req = 0;
  logic [11:0] level = 12'ha50;
  logic [23:0] pins;
  acc_pkg::acc_ana_req_t ana;
  acc_pkg::acc_mode_t md[3] = '{acc_pkg::ACC_MODE_12, acc_pkg::ACC_MODE_10, acc_pkg::ACC_MODE_8};
  logic [7:0] eh[3] = '{8'h0a, 8'h02, 8'h00};
  logic [7:0] el[3] = '{8'h50, 8'h94, 8'ha5};
  int num_errors = 0, checked = 0, cyc = 0, t, tprev;

  acc_conv_ctrl i_acc_conv_ctrl (.i_core_clk(core_clk), .i_reset_n(reset_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .i_alt_clk_en(alt_en), .i_async_clk_en(async_en), .i_hw_trigger(hw_trig), .i_stop_req(stop_req),
    .i_cmp_bit(cmp_bit), .o_ana(ana), .o_irq(irq), .o_pin_port_dis(pins));
  acc_ana_model i_acc_ana_model (.i_core_clk(core_clk), .i_ana(ana), .i_level(level), .o_cmp_bit(cmp_bit));

  always #5 core_clk = ~core_clk;
  // slow source ticks, unrelated rates
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    alt_en <= (cyc % 4 == 0);
    async_en <= (cyc % 3 == 0);
    if (ana.async_clk_on === 1'b1) begin
      seen <= 1'b1;
    end
    if (cyc == 60000) begin
      num_errors = num_errors + 1;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    rr = bresp;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    rv = rdata[7:0];
    rr = rresp;
    @(posedge core_clk);
  endtask

  // reads status one until done shows, returns elapsed cycles
  task automatic poll();
    int n;
    n = 0;
    t = cyc;
    do begin
      rd(acc_pkg::OFF_SC1);
      n++;
    end while (rv[7] !== 1'b1 && n < 300);
    t = cyc - t;
  endtask

  initial begin
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    rd(acc_pkg::OFF_SC1);
    `CHK("sc1 rst", 8'h1f, rv)
    rd(acc_pkg::OFF_CFG);
    `CHK("cfg rst", 8'h00, rv)
    rd(acc_pkg::OFF_RL);
    `CHK("rl rst", 8'h00, rv)
    `CHK("pwr rst", 1'b0, ana.power_on)
    rd(8'h30);
    `CHK("unmapped", acc_pkg::AXI_SLVERR, rr)
    wr(acc_pkg::OFF_PD_UP, 8'h81);
    strb <= 4'h0;
    wr(acc_pkg::OFF_PD_UP, 8'h00);
    strb <= 4'hf;
    rd(acc_pkg::OFF_PD_UP);
    `CHK("pd up", 8'h81, rv)
    `CHK("pins", 24'h810000, pins)
    for (int i = 0; i < 3; i++) begin
      wr(acc_pkg::OFF_CFG, {4'h0, md[i], 2'b00});
      wr(acc_pkg::OFF_SC1, 8'h43);
      poll();
      `CHK("done", 1'b1, rv[7])
      `CHK("irq", 1'b1, irq)
      `CHK("idle pwr", 1'b0, ana.power_on)
      rd(acc_pkg::OFF_RH);
      `CHK("rh", eh[i], rv)
      rd(acc_pkg::OFF_RL);
      `CHK("rl", el[i], rv)
      @(posedge core_clk);
      `CHK("irq clr", 1'b0, irq)
    end
    tprev = 0;
    for (int d = 0; d < 4; d++) begin
      wr(acc_pkg::OFF_CFG, {1'b0, 2'(d), 5'b00100});
      wr(acc_pkg::OFF_SC1, 8'h03);
      poll();
      `CHK("div slower", 1'b1, t > tprev)
      tprev = t;
    end
    for (int c = 0; c < 4; c++) begin
      wr(acc_pkg::OFF_CFG, {6'b000001, 2'(c)});
      seen = 1'b0;
      wr(acc_pkg::OFF_SC1, 8'h03);
      poll();
      `CHK("src done", 1'b1, rv[7])
      `CHK("async on", c == 3, seen)
    end
    wr(acc_pkg::OFF_CFG, 8'h84);
    wr(acc_pkg::OFF_SC1, 8'h03);
    `CHK("low power", 1'b1, ana.low_power)
    poll();
    wr(acc_pkg::OFF_SC2, 8'h40);
    wr(acc_pkg::OFF_SC1, 8'h23);
    rd(acc_pkg::OFF_SC2);
    `CHK("no sw start", 1'b0, rv[7])
    hw_trig <= 1'b1;
    repeat (2) @(posedge core_clk);
    hw_trig <= 1'b0;
    rd(acc_pkg::OFF_SC2);
    `CHK("hw start", 1'b1, rv[7])
    hw_trig <= 1'b1;
    @(posedge core_clk);
    hw_trig <= 1'b0;
    poll();
    rd(acc_pkg::OFF_RL);
    poll();
    `CHK("cont again", 1'b1, rv[7])
    wr(acc_pkg::OFF_SC2, 8'h00);
    rd(acc_pkg::OFF_SC2);
    `CHK("sc2 abort", 1'b0, rv[7])
    wr(acc_pkg::OFF_SC1, 8'h23);
    poll();
    rd(acc_pkg::OFF_RL);
    rd(acc_pkg::OFF_RH);
    level <= 12'h3c0;
    repeat (300) @(posedge core_clk);
    rd(acc_pkg::OFF_SC1);
    `CHK("blocked", 1'b0, rv[7])
    rd(acc_pkg::OFF_SC2);
    `CHK("restart", 1'b1, rv[7])
    rd(acc_pkg::OFF_RL);
    `CHK("kept", 8'h50, rv)
    poll();
    rd(acc_pkg::OFF_RH);
    `CHK("new rh", 8'h03, rv)
    wr(acc_pkg::OFF_CVL, 8'h00);
    rd(acc_pkg::OFF_SC2);
    `CHK("cv abort", 1'b0, rv[7])
    rd(acc_pkg::OFF_RL);
    `CHK("abort keeps", 8'hc0, rv)
    wr(acc_pkg::OFF_CFG, 8'h64);
    wr(acc_pkg::OFF_SC1, 8'h03);
    stop_req <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd(acc_pkg::OFF_SC2);
    `CHK("stop abort", 1'b0, rv[7])
    stop_req <= 1'b0;
    wr(acc_pkg::OFF_CVH, 8'h01);
    wr(acc_pkg::OFF_CFG, 8'h04);
    wr(acc_pkg::OFF_SC2, 8'h30);
    wr(acc_pkg::OFF_SC1, 8'h03);
    poll();
    rd(acc_pkg::OFF_RH);
    `CHK("cmp diff", 8'h02, rv)
    rd(acc_pkg::OFF_RL);
    wr(acc_pkg::OFF_CVH, 8'h04);
    rd(acc_pkg::OFF_RH);
    wr(acc_pkg::OFF_SC1, 8'h03);
    repeat (200) @(posedge core_clk);
    rd(acc_pkg::OFF_SC1);
    `CHK("cmp false", 1'b0, rv[7])
    rd(acc_pkg::OFF_SC2);
    `CHK("cmp ends", 1'b0, rv[7])
    wr(acc_pkg::OFF_SC2, 8'h00);
    wr(acc_pkg::OFF_SC1, 8'h1f);
    rd(acc_pkg::OFF_SC2);
    `CHK("ch off", 1'b0, rv[7])
    `CHK("ch off pwr", 1'b0, ana.power_on)
    end_sim();
  end
endmodule
